/* rtl/aios_top.sv */
// Purpose: Input/output supervision and error mode of arc protection unit
// Assumes: One clock, power-on reset, switches static
// Notes: Trip schemes left out; signals arrive as plain ports
// How it works
// - Supervise fourteen sensor channels after setup
// - Switch selects loop sensor or quench link
// - Loop mode sends test light, checks return
// - Quench mode sends continuous test pulses
// - Two wired inputs with switch functions
// - Lost wired input contact forces error
// - Wired output emits liveness pulse each second
// - Fast output emits liveness pulse each second, except when its switch selects trip
// - Switches select wired output signal
// - Switches select fast output trip or signal
// - Fault relay energized only while healthy
// - Read eight configuration switches
`timescale 1ns/1ps
`include "aios_map.svh"
module aios_top #(
  parameter int PERIOD_CYC = `AIOS_LIVE_PERIOD_CYC,
  parameter int TIMEOUT_CYC = `AIOS_LIVE_TIMEOUT_CYC,
  parameter int LOOP_PERIOD_CYC = `AIOS_LOOP_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Configuration
  input wire logic [7:0] cfg_switch,
  input wire logic setup_done,
  // Point sensors
  input wire logic [13:0] sensor_ok,
  input wire logic [13:0] sensor_light,
  // Optional loop channel
  output logic optional_loop_channel_tx,
  input wire logic optional_loop_channel_rx,
  input wire logic quench_unit_ack,
  // Wired inputs and peer signals
  input wire logic [1:0] wired_input,
  input wire logic overcurrent,
  input wire logic master_trip,
  input wire logic breaker_trip,
  // Outputs
  output logic wired_output,
  output logic fast_output,
  output logic fault_relay,
  output logic error_mode,
  output aios_pkg::aios_func_t [1:0] in_func,
  output logic [1:0] in_active
);
  import aios_pkg::*;
  aios_live_if live();
  logic opt_quench;
  logic fast_trip_mode;
  aios_func_t wout_func;
  logic [1:0] watch_en;
  logic light_any;
  logic sensor_err;
  logic loop_err_reg;
  logic quench_err_reg;
  logic err_any;
  aios_loop_t lp_reg;
  aios_loop_t lp_next;
  logic [31:0] lp_cnt_reg;
  logic [31:0] qh_cnt_reg;
  logic q_tx_reg;
  logic wout_reg;
  logic fast_reg;
  logic relay_reg;
  logic wout_sig;
  logic fast_sig;
  logic q_last_ack_reg;
  logic [31:0] q_gap_reg;
  logic loop_tx;
  //----------------------------------------
  // Switch decode
  //----------------------------------------
  assign opt_quench = cfg_switch[`AIOS_CFG_OPT_MODE];
  assign fast_trip_mode = cfg_switch[`AIOS_CFG_FAST_MODE];
  assign wout_func = aios_func_t'(cfg_switch[`AIOS_CFG_WOUT_LO +: 2]);
  // Input functions
  assign in_func[0] = aios_func_t'(cfg_switch[`AIOS_CFG_IN0_LO +: 2]);
  assign in_func[1] = aios_func_t'(cfg_switch[`AIOS_CFG_IN1_LO +: 2]);
  assign watch_en[0] = setup_done && (in_func[0] != AIOS_FN_OFF);
  assign watch_en[1] = setup_done && (in_func[1] != AIOS_FN_OFF);
  // Supervise sensors
  assign sensor_err = setup_done && (sensor_ok != 14'h3FFF);
  assign light_any = (|sensor_light) || (!opt_quench && optional_loop_channel_rx && lp_reg == AIOS_LP_IDLE);
  assign err_any = sensor_err || loop_err_reg || quench_err_reg || (|live.lost);
  // Wired output signal select
  assign wout_sig = (wout_func == AIOS_FN_LIGHT) ? light_any :
                    (wout_func == AIOS_FN_TRIP) ? master_trip :
                    (wout_func == AIOS_FN_OVERCUR) ? overcurrent : 1'b0;
  assign fast_sig = fast_trip_mode ? breaker_trip : (overcurrent || light_any);
  // Wired input decode, liveness pulses filtered by function
  assign in_active = wired_input & watch_en;
  aios_input_watch #(
    .PERIOD_CYC(PERIOD_CYC),
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_watch (
    .clk(clk),
    .rst_b(rst_b),
    .wired_input(wired_input),
    .watch_en(watch_en),
    .live(live)
  );
  //----------------------------------------
  // Fiber loop test sequencer
  //----------------------------------------
  always_comb begin
    lp_next = lp_reg;
    case (lp_reg)
      AIOS_LP_IDLE: if (!opt_quench && lp_cnt_reg >= 32'(LOOP_PERIOD_CYC - 1)) lp_next = AIOS_LP_SEND;
      AIOS_LP_SEND: lp_next = AIOS_LP_WAIT;
      AIOS_LP_WAIT: if (optional_loop_channel_rx || lp_cnt_reg == 32'(`AIOS_LOOP_WAIT_CYC)) lp_next = AIOS_LP_IDLE;
      default: lp_next = AIOS_LP_IDLE;
    endcase
  end
  // Test light and return
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lp_reg <= AIOS_LP_IDLE;
      lp_cnt_reg <= 32'h0;
      loop_err_reg <= 1'b0;
    end else begin
      lp_reg <= lp_next;
      lp_cnt_reg <= (lp_next != lp_reg) ? 32'h0 : lp_cnt_reg + 32'h1;
      if (opt_quench) begin
        loop_err_reg <= 1'b0;
      end else if (lp_reg == AIOS_LP_WAIT && optional_loop_channel_rx) begin
        loop_err_reg <= 1'b0;
      end else if (lp_reg == AIOS_LP_WAIT && lp_cnt_reg == 32'(`AIOS_LOOP_WAIT_CYC)) begin
        loop_err_reg <= 1'b1;
      end
    end
  end
  assign loop_tx = (lp_reg == AIOS_LP_SEND);
  //----------------------------------------
  // Quench link test pulses
  //----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qh_cnt_reg <= 32'h0;
      q_tx_reg <= 1'b0;
      q_last_ack_reg <= 1'b0;
      q_gap_reg <= 32'h0;
      quench_err_reg <= 1'b0;
    end else begin
      // Continuous square pulse train
      if (qh_cnt_reg == 32'(`AIOS_QUENCH_HALF_CYC - 1)) begin
        qh_cnt_reg <= 32'h0;
        q_tx_reg <= ~q_tx_reg;
      end else begin
        qh_cnt_reg <= qh_cnt_reg + 32'h1;
      end
      q_last_ack_reg <= quench_unit_ack;
      // Missing receipt acknowledge forces error
      if (!opt_quench || (quench_unit_ack && !q_last_ack_reg)) begin
        q_gap_reg <= 32'h0;
        quench_err_reg <= 1'b0;
      end else if (q_gap_reg == 32'(TIMEOUT_CYC)) begin
        quench_err_reg <= 1'b1;
      end else begin
        q_gap_reg <= q_gap_reg + 32'h1;
      end
    end
  end
  //----------------------------------------
  // Outputs and fault relay
  //----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wout_reg <= 1'b0;
      fast_reg <= 1'b0;
      relay_reg <= 1'b0;
      optional_loop_channel_tx <= 1'b0;
    end else begin
      wout_reg <= wout_sig || live.pulse;
      fast_reg <= fast_sig || (!fast_trip_mode && live.pulse);
      relay_reg <= !err_any;
      optional_loop_channel_tx <= opt_quench ? q_tx_reg : loop_tx;
    end
  end
  assign wired_output = wout_reg;
  assign fast_output = fast_reg;
  assign fault_relay = relay_reg;
  assign error_mode = !relay_reg;
  //----------------------------------------
  // Checks
  //----------------------------------------
  a_relay_err: assert property (@(posedge clk) disable iff (!rst_b)
    err_any |=> !fault_relay) else $error("relay held on error");
  a_relay_heal: assert property (@(posedge clk) disable iff (!rst_b)
    !err_any |=> fault_relay) else $error("relay not energized");
  a_sensor_err: assert property (@(posedge clk) disable iff (!rst_b)
    sensor_err |-> ##1 error_mode) else $error("sensor fault missed");
  a_wire_lost: assert property (@(posedge clk) disable iff (!rst_b)
    (|live.lost) |=> error_mode) else $error("lost input missed");
  a_wout_live: assert property (@(posedge clk) disable iff (!rst_b)
    live.pulse |=> wired_output) else $error("no wired liveness");
  a_fast_live: assert property (@(posedge clk) disable iff (!rst_b)
    (live.pulse && !fast_trip_mode) |=> fast_output) else $error("no fast liveness");
  sequence s_loop_miss;
    lp_reg == AIOS_LP_WAIT && !optional_loop_channel_rx && lp_cnt_reg == 32'(`AIOS_LOOP_WAIT_CYC) && !opt_quench;
  endsequence
  a_loop_miss: assert property (@(posedge clk) disable iff (!rst_b)
    s_loop_miss |=> loop_err_reg ##1 error_mode) else $error("loop break missed");
  a_loop_send: assert property (@(posedge clk) disable iff (!rst_b)
    (lp_reg == AIOS_LP_SEND && !opt_quench) |=> optional_loop_channel_tx) else $error("no test light");
  a_loop_restart: assert property (@(posedge clk) disable iff (!rst_b)
    (lp_reg == AIOS_LP_IDLE && !opt_quench && lp_cnt_reg >= 32'(LOOP_PERIOD_CYC - 1)) |=> lp_reg == AIOS_LP_SEND)
    else $error("test light not restarted");
  a_quench_tx: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(q_tx_reg) && opt_quench && $past(opt_quench) |=> $changed(optional_loop_channel_tx))
    else $error("quench pulse lost");
  sequence s_quench_miss;
    opt_quench && q_gap_reg == 32'(TIMEOUT_CYC) && !(quench_unit_ack && !q_last_ack_reg);
  endsequence
  a_quench_miss: assert property (@(posedge clk) disable iff (!rst_b)
    s_quench_miss |=> quench_err_reg ##1 error_mode) else $error("quench link loss missed");
  a_wout_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (wout_func == AIOS_FN_TRIP && master_trip) |=> wired_output) else $error("wired select wrong");
  a_fast_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (fast_trip_mode && breaker_trip) |=> fast_output) else $error("fast trip wrong");
endmodule

/* rtl/aios_map.svh */
// Purpose: Constants for arc input/output supervision
// Assumes: 100 MHz clock
// Notes: Times in their own unit, counts derived
`ifndef AIOS_MAP_SVH
`define AIOS_MAP_SVH
`define AIOS_CLK_MHZ 100
`define AIOS_SENSOR_CH 14
`define AIOS_WIRED_IN 2
`define AIOS_CFG_BITS 8
`define AIOS_LIVE_PERIOD_MS 1000
`define AIOS_LIVE_PERIOD_CYC (`AIOS_LIVE_PERIOD_MS * 1000 * `AIOS_CLK_MHZ)
`define AIOS_LIVE_PULSE_US 100
`define AIOS_LIVE_PULSE_CYC (`AIOS_LIVE_PULSE_US * `AIOS_CLK_MHZ)
`define AIOS_LIVE_TIMEOUT_MS 3000
`define AIOS_LIVE_TIMEOUT_CYC (`AIOS_LIVE_TIMEOUT_MS * 1000 * `AIOS_CLK_MHZ)
`define AIOS_LOOP_PERIOD_MS 10
`define AIOS_LOOP_PERIOD_CYC (`AIOS_LOOP_PERIOD_MS * 1000 * `AIOS_CLK_MHZ)
`define AIOS_LOOP_WAIT_US 10
`define AIOS_LOOP_WAIT_CYC (`AIOS_LOOP_WAIT_US * `AIOS_CLK_MHZ)
`define AIOS_QUENCH_HALF_US 50
`define AIOS_QUENCH_HALF_CYC (`AIOS_QUENCH_HALF_US * `AIOS_CLK_MHZ)
// Configuration switch fields
`define AIOS_CFG_OPT_MODE 0
`define AIOS_CFG_IN0_LO 1
`define AIOS_CFG_IN1_LO 3
`define AIOS_CFG_WOUT_LO 5
`define AIOS_CFG_FAST_MODE 7
`endif

/* rtl/aios_pkg.sv */
// Purpose: Types for arc input/output supervision
// Assumes: Constants in aios_map.svh
// Notes: None
package aios_pkg;
  typedef enum logic [1:0] {
    AIOS_FN_LIGHT = 2'b00,
    AIOS_FN_TRIP = 2'b01,
    AIOS_FN_OVERCUR = 2'b10,
    AIOS_FN_OFF = 2'b11
  } aios_func_t;
  typedef enum logic [1:0] {
    AIOS_LP_IDLE = 2'b00,
    AIOS_LP_SEND = 2'b01,
    AIOS_LP_WAIT = 2'b10
  } aios_loop_t;
  typedef logic [7:0] aios_count_t;
endpackage

/* rtl/aios_live_if.sv */
// Purpose: Pulse bundle from the liveness counter
// Assumes: One clock
// Notes: None
`timescale 1ns/1ps
interface aios_live_if;
  logic pulse;
  logic [1:0] lost;
  modport src (output pulse, output lost);
  modport mon (input pulse, input lost);
endinterface

/* rtl/aios_input_watch.sv */
// Purpose: Liveness pulse source and per-input timeout watch
// Assumes: Inputs synchronous to clk
// Notes: Timeout is a parameter
`timescale 1ns/1ps
`include "aios_map.svh"
module aios_input_watch #(
  parameter int PERIOD_CYC = `AIOS_LIVE_PERIOD_CYC,
  parameter int TIMEOUT_CYC = `AIOS_LIVE_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  // Wired inputs and which are expected live
  input wire logic [1:0] wired_input,
  input wire logic [1:0] watch_en,
  // Pulse bundle
  aios_live_if.src live
);
  import aios_pkg::*;
  logic [31:0] per_reg;
  logic [31:0] per_next;
  assign per_next = (per_reg == 32'(PERIOD_CYC - 1)) ? 32'h0 : per_reg + 32'h1;
  // Pulse high for first stretch of each second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      per_reg <= 32'h0;
    end else begin
      per_reg <= per_next;
    end
  end
  assign live.pulse = per_reg < 32'(`AIOS_LIVE_PULSE_CYC);
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_in
      logic last_reg;
      logic [31:0] tmo_reg;
      logic rise;
      assign rise = wired_input[g] & ~last_reg;
      // Lost when no pulse within timeout
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          last_reg <= 1'b0;
          tmo_reg <= 32'h0;
        end else begin
          last_reg <= wired_input[g];
          if (rise || !watch_en[g]) begin
            tmo_reg <= 32'h0;
          end else if (tmo_reg != 32'(TIMEOUT_CYC)) begin
            tmo_reg <= tmo_reg + 32'h1;
          end
        end
      end
      assign live.lost[g] = watch_en[g] && (tmo_reg == 32'(TIMEOUT_CYC));
      a_lost_timeout: assert property (@(posedge clk) disable iff (!rst_b)
        rise |=> !live.lost[g]) else $error("lost right after pulse");
    end
  endgenerate
endmodule

/* verif/aios_peer_model.sv */
// Purpose: Far side of supervision block: loop fiber, quench unit, peers
// Assumes: One clock, peer pulses free running from time zero
// Notes: Faults injected by cut and break controls
`timescale 1ns/1ps
module aios_peer_model #(
  parameter int PERIOD_CYC = 11000
) (
  input wire logic clk,
  // Fault controls
  input wire logic loop_break,
  input wire logic quench_cut,
  input wire logic [1:0] peer_cut,
  // Optional channel
  input wire logic loop_tx,
  output logic loop_rx,
  output logic quench_ack,
  // Peer outputs
  output logic [1:0] wired_in
);
  int cnt = 0;
  initial begin
    loop_rx = 1'b0;
    quench_ack = 1'b0;
  end
  // ----------------------------------------
  // Echo and pulses
  // ----------------------------------------
  always @(posedge clk) begin
    cnt <= (cnt == PERIOD_CYC - 1) ? 0 : cnt + 1;
    loop_rx <= loop_tx & !loop_break;
    quench_ack <= loop_tx & !quench_cut;
  end
  assign wired_in = (cnt < 100) ? ~peer_cut : 2'b00;
endmodule

/* verif/testbench.sv */
// Purpose: Self-checking bench for supervision block
// Assumes: Shortened period and timeout parameters
// Notes: Tests are sequences of drive and compare calls
`timescale 1ns/1ps
module testbench;
  import aios_pkg::*;
  localparam int P = 11000;
  localparam int TO = 15000;
  logic clk, rst_b, setup_done, overcurrent, master_trip, breaker_trip;
  logic loop_tx, loop_rx, quench_ack, loop_break, quench_cut;
  logic wired_output, fast_output, fault_relay, error_mode;
  logic [7:0] cfg_switch;
  logic [13:0] sensor_ok, sensor_light;
  logic [1:0] wired_in, peer_cut, in_active;
  aios_pkg::aios_func_t [1:0] in_func;
  int err_total = 0;
  int checks = 0;
  int n;
  int chs[2] = '{0, 13};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  aios_top #(.PERIOD_CYC(P), .TIMEOUT_CYC(TO), .LOOP_PERIOD_CYC(50)) u_dut (.clk(clk), .rst_b(rst_b),
    .cfg_switch(cfg_switch), .setup_done(setup_done), .sensor_ok(sensor_ok), .sensor_light(sensor_light),
    .optional_loop_channel_tx(loop_tx), .optional_loop_channel_rx(loop_rx), .quench_unit_ack(quench_ack),
    .wired_input(wired_in), .overcurrent(overcurrent), .master_trip(master_trip), .breaker_trip(breaker_trip),
    .wired_output(wired_output), .fast_output(fast_output), .fault_relay(fault_relay),
    .error_mode(error_mode), .in_func(in_func), .in_active(in_active));
  aios_peer_model #(.PERIOD_CYC(P)) u_peer (.clk(clk), .loop_break(loop_break), .quench_cut(quench_cut),
    .peer_cut(peer_cut), .loop_tx(loop_tx), .loop_rx(loop_rx), .quench_ack(quench_ack), .wired_in(wired_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wait_err(input logic exp, input int max);
    for (int i = 0; i < max && error_mode !== exp; i++) tick(1);
    chk(error_mode, exp);
    chk(fault_relay, !exp);
  endtask
  task pulse_len(input logic lvl, output int k);
    k = 0;
    while (wired_output === lvl && k < P) begin
      tick(1);
      k++;
    end
  endtask
  task step(input logic [7:0] c, input logic [3:0] s);
    @(posedge clk);
    cfg_switch <= c;
    {breaker_trip, sensor_light[0], master_trip, overcurrent} <= s;
    tick(3);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    setup_done = 1'b1;
    cfg_switch = 8'h00;
    sensor_ok = 14'h3FFF;
    sensor_light = 14'h0000;
    {overcurrent, master_trip, breaker_trip, loop_break, quench_cut} = 5'h00;
    peer_cut = 2'b00;
    tick(2);
    chk(fault_relay, 1'b0);
    chk(error_mode, 1'b1);
    @(posedge clk) rst_b <= 1'b1;
    wait_err(1'b0, 20);
    pulse_len(1'b1, n);
    pulse_len(1'b0, n);
    chk(n, P - 10000);
    chk(fast_output, 1'b1);
    pulse_len(1'b1, n);
    chk(n, 10000);
    chk(fast_output, 1'b0);
    $display("liveness test done");
    for (int f = 0; f < 4; f++) begin
      step({1'b0, f[1:0], f[1:0], f[1:0], 1'b0}, {1'b0, ~(3'b100 >> f)});
      chk(wired_output, 1'b0);
      step({1'b0, f[1:0], f[1:0], f[1:0], 1'b0}, {1'b0, 3'b100 >> f});
      chk(wired_output, f != 3);
      chk(in_func[0], 16'(f));
      chk(in_func[1], 16'(f));
    end
    step(8'h80, 4'h8);
    chk(fast_output, 1'b1);
    step(8'h80, 4'h1);
    chk(fast_output, 1'b0);
    step(8'h00, 4'h1);
    chk(fast_output, 1'b1);
    step(8'h00, 4'h0);
    $display("switch test done");
    foreach (chs[i]) begin
      @(posedge clk);
      setup_done <= 1'b0;
      sensor_ok <= 14'h3FFF ^ (14'h0001 << chs[i]);
      tick(5);
      chk(error_mode, 1'b0);
      @(posedge clk) setup_done <= 1'b1;
      wait_err(1'b1, 10);
      @(posedge clk) sensor_ok <= 14'h3FFF;
      wait_err(1'b0, 10);
    end
    $display("sensor test done");
    @(posedge clk) loop_break <= 1'b1;
    wait_err(1'b1, 1200);
    @(posedge clk) loop_break <= 1'b0;
    wait_err(1'b0, 1200);
    @(posedge clk) cfg_switch <= 8'h01;
    loop_break <= 1'b1;
    tick(3000);
    chk(error_mode, 1'b0);
    @(posedge clk) quench_cut <= 1'b1;
    wait_err(1'b1, TO + 200);
    @(posedge clk) quench_cut <= 1'b0;
    wait_err(1'b0, 11000);
    $display("optional channel test done");
    @(posedge clk) cfg_switch <= 8'h18;
    loop_break <= 1'b0;
    peer_cut <= 2'b11;
    tick(TO - P - 1000);
    chk(error_mode, 1'b0);
    wait_err(1'b1, P + 2000);
    @(posedge clk) peer_cut <= 2'b10;
    wait_err(1'b0, P + 200);
    @(posedge clk) peer_cut <= 2'b00;
    tick(1);
    for (int i = 0; i < P && wired_in !== 2'b11; i++) tick(1);
    chk(in_active, 2'b01);
    $display("wired input test done");
    @(posedge clk) loop_break <= 1'b1;
    wait_err(1'b1, 1200);
    @(posedge clk) loop_break <= 1'b0;
    wait_err(1'b0, 1200);
    $display("loop recovery test done");
    summarize();
  end
  initial begin
    #950_000;
    err_total++;
    summarize();
  end
endmodule
